// File: resolver_position_tracker.sv
module resolver_position_tracker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Sensor side
    output logic carrier_out,
    input wire logic signed [15:0] sin_sample,
    input wire logic signed [15:0] cos_sample,
    input wire logic [15:0] angle_in,
    input wire logic hw_fault,
    // Configuration
    input wire logic count_clear,
    input wire logic count_direction_invert,
    input wire logic [1:0] fault_source,
    input wire logic fault_clear,
    input wire logic [4:0] pole_count,
    input wire logic [6:0] belt_reduction_factor,
    input wire logic signed [15:0] angle_offset,
    input wire logic [9:0] speed_cutoff_hz,
    input wire logic [7:0] phase_shift_deg,
    // Status
    output logic [31:0] quad_position_count,
    output logic [15:0] electrical_angle,
    output logic signed [15:0] speed_filtered,
    output logic feedback_fault,
    output logic setup_done
);
    typedef struct packed {
        logic [4:0] pre;
        logic [8:0] phase;
        logic carrier;
        logic [15:0] prev_angle;
        logic have_prev;
        logic [31:0] pos;
        logic [15:0] elec;
        logic fault;
        logic [4:0] init_cnt;
        logic done;
        logic speed_v;
        logic signed [15:0] delta;
    } track_state_type;

    track_state_type s_r, s_nxt;
    logic sample_now;
    logic [8:0] shift_c;
    logic [9:0] sample_sum;
    logic [8:0] sample_deg;
    logic [1:0] low_amp;
    logic sw_trip;
    logic trip_now;
    logic [4:0] poles_c;
    logic [6:0] belt_c;
    logic [10:0] mult;
    logic [15:0] step;
    logic signed [15:0] filt_y;

    // ----------------------------------------
    // Carrier phase and sample point
    // ----------------------------------------
    // Sampling point slides by the configured carrier phase shift
    always_comb begin
        shift_c = {1'b0, phase_shift_deg};
        if (shift_c > resolver_pkg::PHASE_SHIFT_MAX) begin
            shift_c = resolver_pkg::PHASE_SHIFT_MAX;
        end
        sample_sum = {1'b0, resolver_pkg::SAMPLE_DEG} + {1'b0, shift_c};
        if (sample_sum > {1'b0, resolver_pkg::PHASE_LAST}) begin
            sample_sum = sample_sum - 10'(resolver_pkg::DEG_PER_TURN);
        end
        sample_deg = sample_sum[8:0];
        sample_now = (s_r.pre == resolver_pkg::PRE_LAST) && (s_r.phase == sample_deg);
    end

    // ----------------------------------------
    // Software amplitude detector
    // ----------------------------------------
    // Per channel magnitude below trip level
    for (genvar g = 0; g < 2; g++) begin : g_amp
        logic signed [15:0] smp;
        logic [15:0] mag;
        assign smp = (g == 0) ? sin_sample : cos_sample;
        assign mag = smp[15] ? 16'(-smp) : smp;
        assign low_amp[g] = (mag < resolver_pkg::TRIP_CODE);
    end
    assign sw_trip = &low_amp;

    // Fault source selection
    always_comb begin
        case (resolver_pkg::fault_source_type'(fault_source))
            resolver_pkg::both_detectors: trip_now = hw_fault || sw_trip;
            resolver_pkg::hw_detector_only: trip_now = hw_fault;
            resolver_pkg::sw_detector_only: trip_now = sw_trip;
            default: trip_now = sw_trip;
        endcase
    end

    // ----------------------------------------
    // Angle scaling
    // ----------------------------------------
    // Pole pairs times belt factor, out-of-range values fall back
    always_comb begin
        poles_c = pole_count;
        if (poles_c < resolver_pkg::POLES_MIN || poles_c > resolver_pkg::POLES_MAX) begin
            poles_c = resolver_pkg::POLES_MIN;
        end
        belt_c = belt_reduction_factor;
        if (belt_c < resolver_pkg::BELT_MIN || belt_c > resolver_pkg::BELT_MAX) begin
            belt_c = resolver_pkg::BELT_MIN;
        end
        mult = 11'(poles_c[4:1] * belt_c);
    end

    // Angle step since last sample, before the direction sign is applied
    assign step = angle_in - s_r.prev_angle;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.speed_v = 1'b0;
        // Degree prescaler and carrier phase
        if (s_r.pre == resolver_pkg::PRE_LAST) begin
            s_nxt.pre = '0;
            if (s_r.phase == resolver_pkg::PHASE_LAST) begin
                s_nxt.phase = '0;
                if (!s_r.done) begin
                    s_nxt.init_cnt = s_r.init_cnt + 5'h01;
                end
            end else begin
                s_nxt.phase = s_r.phase + 9'h001;
            end
        end else begin
            s_nxt.pre = s_r.pre + 5'h01;
        end
        s_nxt.carrier = (s_nxt.phase < 9'(resolver_pkg::DEG_PER_TURN / 2));
        // Initialisation finishes after a set number of carrier periods
        if (s_r.init_cnt == resolver_pkg::INIT_PERIODS) begin
            s_nxt.done = 1'b1;
        end
        // Position tracking at each sample point
        if (sample_now) begin
            s_nxt.prev_angle = angle_in;
            s_nxt.have_prev = 1'b1;
            if (s_r.have_prev) begin
                s_nxt.delta = count_direction_invert ? 16'(-step) : step;
                s_nxt.speed_v = 1'b1;
                s_nxt.pos = s_r.pos + {{16{s_nxt.delta[15]}}, s_nxt.delta};
            end
            s_nxt.elec = 16'(angle_in * mult) + angle_offset;
        end
        // Clear holds count at zero while asserted
        if (count_clear) begin
            s_nxt.pos = '0;
        end
        // Fault is sticky; a new trip wins over a clear
        if (fault_clear) begin
            s_nxt.fault = 1'b0;
        end
        if (sample_now && s_r.done && trip_now) begin
            s_nxt.fault = 1'b1;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Speed filter on per-sample step
    speed_filter u_speed_filter (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_valid(s_r.speed_v),
        .speed_raw(s_r.delta),
        .cutoff_hz(speed_cutoff_hz),
        .speed_out(filt_y)
    );

    assign carrier_out = s_r.carrier;
    assign quad_position_count = s_r.pos;
    assign electrical_angle = s_r.elec;
    assign speed_filtered = filt_y;
    assign feedback_fault = s_r.fault;
    assign setup_done = s_r.done;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_clear_zeroes: assert property (@(posedge sys_clk) disable iff (sys_rst)
        count_clear |=> quad_position_count == 32'h0000_0000)
        else $error("position not zero after clear");

    a_count_forward: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (sample_now && s_r.have_prev && !count_clear && !count_direction_invert)
        |=> quad_position_count == $past(s_r.pos) + {{16{$past(step[15])}}, $past(step)})
        else $error("position step wrong without inversion");

    a_count_invert: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (sample_now && s_r.have_prev && !count_clear && count_direction_invert)
        |=> $signed(s_r.delta) == -$signed($past(step)))
        else $error("position step not inverted");

    a_hold_between: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!sample_now && !count_clear) |=> $stable(quad_position_count))
        else $error("position moved between samples");

    a_hw_only: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (fault_source == 2'h1 && sample_now && setup_done && hw_fault) |=> feedback_fault)
        else $error("hardware trip not flagged");

    a_sw_ignores_hw: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (fault_source == 2'h2 && !feedback_fault && !sw_trip) |=> !feedback_fault)
        else $error("fault flagged without software trip");

    a_fault_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (feedback_fault && !fault_clear) |=> feedback_fault)
        else $error("fault flag dropped without clear");

    a_setup_timing: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (s_r.init_cnt == resolver_pkg::INIT_PERIODS && !setup_done) |=> setup_done)
        else $error("setup done not raised after init");

    a_no_fault_early: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!setup_done && !feedback_fault) |=> !feedback_fault)
        else $error("fault raised during initialisation");
endmodule

// File: resolver_pkg.sv
// Notes on behaviour
// - The position count advances 65536 steps per resolver division and is readable.
// - The position count is zero after power-up.
// - While the clear input is high the position count is held at zero; it defaults low.
// - Without inversion clockwise rotation raises the count; with inversion it lowers it.
// - Fault source code 0 uses both detectors, 1 hardware only, 2 software only (default 2).
// - The fault flag is low while healthy and goes high once a fault is detected.
// - The setup done flag is low during initialisation and high once it has finished.
// - Software detection trips when sine and cosine fall below 0.15*(Vc*0.1414*ratio*2.0).
// - Pole counts from 2 to 20 are accepted, 2 standard, and may carry a belt reduction.
// - An electrical angle offset of -180 to 180 degrees is added, default zero.
// - Speed is low-pass filtered with a cutoff of 10 to 1000 Hz, default 100 Hz.
// - A carrier to signal phase shift of 0 to 180 degrees is compensated, default zero.
package resolver_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int CARRIER_HZ = 8000;
    localparam int DEG_PER_TURN = 360;
    localparam int DEG_PRESCALE = CLK_HZ / (CARRIER_HZ * DEG_PER_TURN);
    localparam logic [4:0] PRE_LAST = 5'(DEG_PRESCALE - 1);
    localparam logic [8:0] PHASE_LAST = 9'(DEG_PER_TURN - 1);
    localparam logic [8:0] SAMPLE_DEG = 9'h05A;
    localparam logic [8:0] PHASE_SHIFT_MAX = 9'h0B4;
    localparam logic [4:0] INIT_PERIODS = 5'h09;
    localparam int SAMPLE_HZ = CLK_HZ / (DEG_PRESCALE * DEG_PER_TURN);
    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int ADC_W = 16;
    localparam int ANGLE_W = 16;
    localparam int POS_W = 32;
    localparam int FILT_FRAC = 8;
    // ----------------------------------------
    // Software trip level
    // ----------------------------------------
    localparam real CARRIER_VRMS = 7.0;
    localparam real RATIO_NOM = 0.5;
    localparam real ADC_FS_V = 10.0;
    localparam real TRIP_LEVEL_V = 0.15 * (CARRIER_VRMS * 0.1414 * RATIO_NOM * 2.0);
    localparam logic [ADC_W-1:0] TRIP_CODE = ADC_W'(int'(TRIP_LEVEL_V / ADC_FS_V * 32768.0));
    // ----------------------------------------
    // Fault source codes and scaling limits
    // ----------------------------------------
    typedef enum logic [1:0] {
        both_detectors = 2'h0,
        hw_detector_only = 2'h1,
        sw_detector_only = 2'h2
    } fault_source_type;
    localparam logic [4:0] POLES_MIN = 5'h02;
    localparam logic [4:0] POLES_MAX = 5'h14;
    localparam logic [6:0] BELT_MIN = 7'h01;
    localparam logic [6:0] BELT_MAX = 7'h64;
    localparam logic [9:0] CUTOFF_MIN = 10'h00A;
    localparam logic [9:0] CUTOFF_MAX = 10'h3E8;
    localparam logic [9:0] CUTOFF_DEF = 10'h064;
    localparam int FILT_K_MAX = 7;
    // Cutoff-to-shift scale, sample rate over two pi
    localparam int FILT_SCALE = int'(real'(SAMPLE_HZ) / 6.2832);
endpackage

// File: speed_filter.sv
module speed_filter (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Raw speed samples
    input wire logic in_valid,
    input wire logic signed [15:0] speed_raw,
    input wire logic [9:0] cutoff_hz,
    // Filtered speed
    output logic signed [15:0] speed_out
);
    typedef struct packed {
        logic signed [15+resolver_pkg::FILT_FRAC:0] acc;
        logic signed [15:0] y;
    } filt_state_type;

    filt_state_type s_r, s_nxt;
    logic [9:0] fc;
    logic [2:0] k;
    logic signed [15+resolver_pkg::FILT_FRAC:0] err;

    // Cutoff clamp and shift choice: alpha about 2^-k
    always_comb begin
        fc = cutoff_hz;
        if (fc < resolver_pkg::CUTOFF_MIN || fc > resolver_pkg::CUTOFF_MAX) begin
            fc = resolver_pkg::CUTOFF_DEF;
        end
        k = 3'h0;
        for (int i = 1; i <= resolver_pkg::FILT_K_MAX; i++) begin
            if ((int'(fc) << i) <= resolver_pkg::FILT_SCALE) begin
                k = 3'(i);
            end
        end
    end

    // First-order low-pass update per sample
    always_comb begin
        s_nxt = s_r;
        err = {speed_raw, {resolver_pkg::FILT_FRAC{1'b0}}} - s_r.acc;
        if (in_valid) begin
            s_nxt.acc = s_r.acc + (err >>> k);
        end
        s_nxt.y = s_nxt.acc[15+resolver_pkg::FILT_FRAC:resolver_pkg::FILT_FRAC];
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign speed_out = s_r.y;

    // Output never moves without a sample
    a_filter_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !$past(in_valid) |-> $stable(speed_out))
        else $error("filtered speed changed without a sample");
endmodule

// File: resolver_sensor_model.sv
module resolver_sensor_model (
    // Bench controls
    input wire logic [15:0] angle_set,
    input wire logic signed [15:0] amp,
    input wire logic hw_trip,
    // Sensor outputs
    output logic signed [15:0] sin_sample,
    output logic signed [15:0] cos_sample,
    output logic [15:0] angle_out,
    output logic hw_fault
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Demodulated winding levels
    // ----------------------------------------
    // Opposite signs so the magnitude path is exercised on both inputs
    always_comb begin
        sin_sample = amp;
        cos_sample = -amp;
        angle_out = angle_set;
        hw_fault = hw_trip;
    end
endmodule

// File: resolver_position_tracker_tb.sv
module resolver_position_tracker_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int SAMPLE_WAIT = 6125; // One sample period plus answer latency
    logic sys_clk, sys_rst, carrier_out, hw_fault, hw_trip;
    logic signed [15:0] sin_sample, cos_sample, amp, angle_offset, speed_filtered;
    logic [15:0] angle_in, angle_set, electrical_angle;
    logic count_clear, count_direction_invert, fault_clear, feedback_fault, setup_done;
    logic [1:0] fault_source;
    logic [4:0] pole_count;
    logic [6:0] belt_reduction_factor;
    logic [9:0] speed_cutoff_hz;
    logic [7:0] phase_shift_deg;
    logic [31:0] quad_position_count, exp_pos;
    int n_fail, n_compared;

    resolver_position_tracker dut_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .carrier_out(carrier_out),
        .sin_sample(sin_sample), .cos_sample(cos_sample), .angle_in(angle_in),
        .hw_fault(hw_fault), .count_clear(count_clear),
        .count_direction_invert(count_direction_invert), .fault_source(fault_source),
        .fault_clear(fault_clear), .pole_count(pole_count),
        .belt_reduction_factor(belt_reduction_factor), .angle_offset(angle_offset),
        .speed_cutoff_hz(speed_cutoff_hz), .phase_shift_deg(phase_shift_deg),
        .quad_position_count(quad_position_count), .electrical_angle(electrical_angle),
        .speed_filtered(speed_filtered), .feedback_fault(feedback_fault),
        .setup_done(setup_done)
    );

    resolver_sensor_model sensor_u (
        .angle_set(angle_set), .amp(amp), .hw_trip(hw_trip),
        .sin_sample(sin_sample), .cos_sample(cos_sample),
        .angle_out(angle_in), .hw_fault(hw_fault)
    );

    // ----------------------------------------
    // Clock
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Move the shaft and track the signed 16-bit step in the expected count
    task automatic step_to(input logic [15:0] a);
        logic signed [15:0] d;
        d = a - angle_set;
        exp_pos = count_direction_invert ? exp_pos - 32'(d) : exp_pos + 32'(d);
        angle_set = a;
        tick(SAMPLE_WAIT);
    endtask

    task automatic final_report;
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tables
    // ----------------------------------------
    logic [4:0] t_pole [3] = '{5'h06, 5'h02, 5'h14};
    logic [6:0] t_belt [3] = '{7'h03 - 7'h02, 7'h03, 7'h01};
    logic [15:0] t_elec [3] = '{16'h1300, 16'h1300, 16'h1A00};
    logic [1:0] f_src [6] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h3};
    logic [15:0] f_amp [6];
    logic f_trip [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    logic f_exp [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int i, exp_n;
        n_fail = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        angle_set = 16'h0000;
        amp = 16'sh2000;
        hw_trip = 1'b0;
        count_clear = 1'b0;
        count_direction_invert = 1'b0;
        fault_source = 2'h2;
        fault_clear = 1'b0;
        pole_count = 5'h02;
        belt_reduction_factor = 7'h01;
        angle_offset = 16'sh0040;
        speed_cutoff_hz = 10'h064;
        phase_shift_deg = 8'h2D;
        exp_pos = 32'h0000_0000;
        f_amp = '{resolver_pkg::TRIP_CODE + 16'h0001, resolver_pkg::TRIP_CODE - 16'h0001,
                  16'h0010, 16'h2000, 16'h0010, 16'h0010};
        tick(10);
        sys_rst = 1'b0;
        check(quad_position_count, 32'h0000_0000);
        // First sample point and carrier fall, counted from reset release
        i = 0;
        while (electrical_angle === 16'h0000 && i < SAMPLE_WAIT) begin
            tick(1);
            i++;
        end
        exp_n = int'(resolver_pkg::SAMPLE_DEG) + int'(phase_shift_deg) + 1;
        check(32'(i), 32'(exp_n * resolver_pkg::DEG_PRESCALE));
        while (carrier_out === 1'b1 && i < SAMPLE_WAIT) begin
            tick(1);
            i++;
        end
        exp_n = resolver_pkg::DEG_PER_TURN / 2;
        check(32'(i), 32'(exp_n * resolver_pkg::DEG_PRESCALE));
        if (i >= SAMPLE_WAIT) begin
            final_report();
        end
        tick(SAMPLE_WAIT - i);
        // Counting, direction, wrap and clear
        step_to(16'h1000);
        check(quad_position_count, exp_pos);
        check({31'h0, speed_filtered[15] === 1'b0 && speed_filtered !== 16'h0000}, 32'h1);
        count_direction_invert = 1'b1;
        step_to(16'h3000);
        check(quad_position_count, exp_pos);
        count_direction_invert = 1'b0;
        step_to(16'hF000);
        check(quad_position_count, exp_pos);
        count_clear = 1'b1;
        tick(2);
        check(quad_position_count, 32'h0000_0000);
        count_clear = 1'b0;
        exp_pos = 32'h0000_0000;
        step_to(16'h0800);
        check(quad_position_count, exp_pos);
        // Scaling and offset, with a hardware trip that must be ignored
        angle_offset = 16'sh1000;
        fault_source = 2'h0;
        hw_trip = 1'b1;
        for (i = 0; i < 3; i++) begin
            pole_count = t_pole[i];
            belt_reduction_factor = t_belt[i];
            step_to(16'h0100);
            check({16'h0, electrical_angle}, {16'h0, t_elec[i]});
        end
        check({31'h0, feedback_fault}, 32'h0);
        check({31'h0, setup_done}, 32'h0);
        hw_trip = 1'b0;
        fault_source = 2'h2;
        i = 0;
        while (setup_done !== 1'b1 && i < 60000) begin
            tick(1);
            i++;
        end
        check({31'h0, setup_done}, 32'h1);
        if (setup_done !== 1'b1) begin
            final_report();
        end
        // Fault source selection and software trip level
        for (i = 0; i < 6; i++) begin
            fault_source = f_src[i];
            amp = f_amp[i];
            hw_trip = f_trip[i];
            tick(SAMPLE_WAIT);
            check({31'h0, feedback_fault}, {31'h0, f_exp[i]});
            amp = 16'sh2000;
            hw_trip = 1'b0;
            fault_clear = 1'b1;
            tick(1);
            fault_clear = 1'b0;
            tick(1);
            check({31'h0, feedback_fault}, 32'h0);
        end
        final_report();
    end
endmodule
